/* rtl/tmr_pkg.sv */
// package for the 16-bit compare / gated / capture timer
// assumes a single mclk domain; nothing else shares these names
package tmr_pkg;

	// ******************************************************
	// widths and fixed values
	// ******************************************************
	localparam int TMR_W = 16;
	localparam int TMR_PS_W = 3;
	localparam logic [15:0] TMR_CNT_RESET = 16'h0000;
	localparam logic [15:0] TMR_CNT_RESTART = 16'h0001;
	localparam logic [15:0] TMR_CNT_MAX = 16'hffff;
	localparam logic [15:0] TMR_CNT_WRAP = 16'h0000;
	localparam logic [15:0] TMR_CAP_RESET = 16'h0000;

	// ******************************************************
	// mode encodings on the mode port
	// ******************************************************
	localparam logic [1:0] TMR_MODE_COMPARE = 2'h0;
	localparam logic [1:0] TMR_MODE_GATED = 2'h1;
	localparam logic [1:0] TMR_MODE_CAPCMP = 2'h2;

	// ******************************************************
	// interrupt source configuration (bit 1 set = restrict)
	// ******************************************************
	localparam logic [1:0] TMR_ICFG_CAP_ONLY = 2'h2;
	localparam logic [1:0] TMR_ICFG_RLD_ONLY = 2'h3;

	// capture/compare arming state
	typedef enum logic {
		TMR_CC_WAIT,
		TMR_CC_RUN
	} tmr_cc_e;

	// interrupt filter, shared by every event source
	function automatic logic tmr_irq_ok(input logic [1:0] cfg,
		input logic is_cap);
		tmr_irq_ok = (cfg == TMR_ICFG_CAP_ONLY) ? is_cap :
			(cfg == TMR_ICFG_RLD_ONLY) ? !is_cap : 1'b1;
	endfunction

	// count step, wraps from the top value
	function automatic logic [15:0] tmr_inc(input logic [15:0] v);
		tmr_inc = (v == TMR_CNT_MAX) ? TMR_CNT_WRAP : v + 16'h0001;
	endfunction

endpackage

/* rtl/tmr_presc.sv */
// prescaler: one-cycle tick every 2**prescale mclk cycles
// assumes enable and prescale come from logic on mclk
`timescale 1ns/100ps
module tmr_presc
	import tmr_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic enable,
	input wire logic [TMR_PS_W-1:0] prescale,
	output logic tick_q
);

	logic [6:0] div_q;
	logic [6:0] div_d;
	logic [6:0] lim;
	logic tick_d;

	// divider restarts whenever the timer is disabled
	always_comb begin
		lim = 7'((8'h01 << prescale) - 8'h01);
		div_d = div_q;
		tick_d = 1'b0;
		if (!enable) begin
			div_d = 7'h00;
		end else if (div_q >= lim) begin
			div_d = 7'h00;
			tick_d = 1'b1;
		end else begin
			div_d = div_q + 7'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			div_q <= 7'h00;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

endmodule // tmr_presc

/* rtl/tmr_top.sv */
// 16-bit timer: compare, gated and capture/compare modes
// assumes control ports are set while enable is low; timer_in is a pin
`timescale 1ns/100ps
module tmr_top
	import tmr_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic enable,
	input wire logic [1:0] mode,
	input wire logic [TMR_PS_W-1:0] prescale,
	input wire logic input_polarity_bit,
	input wire logic [1:0] interrupt_source_config,
	input wire logic out_alt_en,
	input wire logic out_init,
	input wire logic count_load,
	input wire logic [TMR_W-1:0] count_load_value,
	input wire logic [TMR_W-1:0] reload_value,
	input wire logic timer_in,
	output logic [TMR_W-1:0] count_q,
	output logic [TMR_W-1:0] capture_value_pair,
	output logic capture_cause_flag,
	output logic timer_irq_q,
	output logic timer_out_q
);

	// ******************************************************
	// input pin synchroniser and edge detection
	// ******************************************************
	logic tin_s1_q;
	logic tin_s2_q;
	logic tin_s3_q;
	logic tick;
	logic tin_act;
	logic tin_was_act;
	logic sel_edge;
	logic deassert;

	// first stage is read only by the second
	always_ff @(posedge mclk) begin
		if (reset) begin
			tin_s1_q <= 1'b0;
			tin_s2_q <= 1'b0;
			tin_s3_q <= 1'b0;
		end else begin
			tin_s1_q <= timer_in;
			tin_s2_q <= tin_s1_q;
			tin_s3_q <= tin_s2_q;
		end
	end

	// polarity bit picks active level and capture edge
	assign tin_act = tin_s2_q == input_polarity_bit;
	assign tin_was_act = tin_s3_q == input_polarity_bit;
	assign sel_edge = tin_act && !tin_was_act;
	assign deassert = !tin_act && tin_was_act;

	// ******************************************************
	// prescaler
	// ******************************************************
	tmr_presc u_presc (
		.mclk(mclk),
		.reset(reset),
		.enable(enable),
		.prescale(prescale),
		.tick_q(tick)
	);

	// ******************************************************
	// counter, capture and interrupt state
	// ******************************************************
	tmr_cc_e cc_q;
	tmr_cc_e cc_d;
	logic [TMR_W-1:0] count_d;
	logic [TMR_W-1:0] cap_d;
	logic flag_d;
	logic irq_d;
	logic out_d;
	logic match;
	logic cap_ev;

	// match is judged at a tick; the new count is seen next tick
	assign match = tick && count_q == reload_value;
	assign cap_ev = enable && mode == TMR_MODE_CAPCMP &&
		cc_q == TMR_CC_RUN && sel_edge;

	always_comb begin
		cc_d = cc_q;
		count_d = count_q;
		cap_d = capture_value_pair;
		flag_d = capture_cause_flag;
		irq_d = 1'b0;
		out_d = timer_out_q;
		if (!enable) begin
			// re-arm so the next enable waits for a first edge again
			cc_d = TMR_CC_WAIT;
			out_d = out_init;
		end else begin
			case (mode)
			TMR_MODE_COMPARE: begin
				if (tick) begin
					count_d = tmr_inc(count_q);
				end
				if (match) begin
					irq_d = tmr_irq_ok(interrupt_source_config, 1'b0);
					if (out_alt_en) begin
						out_d = !timer_out_q;
					end
				end
			end
			TMR_MODE_GATED: begin
				if (tick && tin_act) begin
					count_d = tmr_inc(count_q);
					if (match) begin
						count_d = TMR_CNT_RESTART;
					end
				end
				if (deassert || (match && tin_act)) begin
					irq_d = tmr_irq_ok(interrupt_source_config, 1'b0);
				end
			end
			TMR_MODE_CAPCMP: begin
				if (cc_q == TMR_CC_WAIT) begin
					if (sel_edge) begin
						cc_d = TMR_CC_RUN;
					end
				end else if (cap_ev) begin
					cap_d = count_q;
					count_d = TMR_CNT_RESTART;
					flag_d = 1'b1;
					irq_d = tmr_irq_ok(interrupt_source_config, 1'b1);
				end else if (match) begin
					count_d = TMR_CNT_RESTART;
					flag_d = 1'b0;
					irq_d = tmr_irq_ok(interrupt_source_config, 1'b0);
				end else if (tick) begin
					count_d = tmr_inc(count_q);
				end
			end
			default: begin
				cc_d = TMR_CC_WAIT;
			end
			endcase
		end
		// software load wins; enable-last ordering is software's duty
		if (count_load) begin
			count_d = count_load_value;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cc_q <= TMR_CC_WAIT;
			count_q <= TMR_CNT_RESET;
			capture_value_pair <= TMR_CAP_RESET;
			capture_cause_flag <= 1'b0;
			timer_irq_q <= 1'b0;
			timer_out_q <= 1'b0;
		end else begin
			cc_q <= cc_d;
			count_q <= count_d;
			capture_value_pair <= cap_d;
			capture_cause_flag <= flag_d;
			timer_irq_q <= irq_d;
			timer_out_q <= out_d;
		end
	end

	// ******************************************************
	// assertions
	// ******************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	logic cmp_run;
	logic cc_run;
	assign cmp_run = enable && mode == TMR_MODE_COMPARE && !count_load;
	assign cc_run = enable && mode == TMR_MODE_CAPCMP && !count_load;

	property p_cmp_match;
		cmp_run && match &&
			interrupt_source_config != TMR_ICFG_CAP_ONLY |=>
			timer_irq_q && count_q == tmr_inc($past(count_q));
	endproperty
	a_cmp_match: assert property (p_cmp_match)
		else $error("compare match gave no interrupt or reloaded");

	property p_cmp_toggle;
		cmp_run && match && out_alt_en |=>
			timer_out_q != $past(timer_out_q);
	endproperty
	a_cmp_toggle: assert property (p_cmp_toggle)
		else $error("timer output not inverted on compare");

	property p_cmp_wrap;
		cmp_run && tick && count_q == TMR_CNT_MAX |=>
			count_q == TMR_CNT_WRAP;
	endproperty
	a_cmp_wrap: assert property (p_cmp_wrap)
		else $error("count did not wrap to zero");

	property p_cmp_pin_ignored;
		cmp_run && !tick |=> $stable(count_q);
	endproperty
	a_cmp_pin_ignored: assert property (p_cmp_pin_ignored)
		else $error("compare count moved without a tick");

	property p_gate_hold;
		enable && mode == TMR_MODE_GATED && !count_load && !tin_act
			|=> $stable(count_q);
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gated count moved while input inactive");

	property p_gate_irq;
		enable && mode == TMR_MODE_GATED && deassert &&
			interrupt_source_config != TMR_ICFG_CAP_ONLY |=> timer_irq_q;
	endproperty
	a_gate_irq: assert property (p_gate_irq)
		else $error("no interrupt on gate deassertion");

	property p_cc_wait;
		cc_run && cc_q == TMR_CC_WAIT |=> $stable(count_q);
	endproperty
	a_cc_wait: assert property (p_cc_wait)
		else $error("count moved before first capture edge");

	property p_capture;
		cc_run && cap_ev |=> capture_value_pair == $past(count_q) &&
			count_q == TMR_CNT_RESTART && capture_cause_flag;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture did not store, restart and flag");

	property p_cc_reload;
		cc_run && !cap_ev && cc_q == TMR_CC_RUN && match |=>
			count_q == TMR_CNT_RESTART && !capture_cause_flag;
	endproperty
	a_cc_reload: assert property (p_cc_reload)
		else $error("compare reload did not restart or clear flag");

	property p_cap_only;
		interrupt_source_config == TMR_ICFG_CAP_ONLY && !cap_ev
			|=> !timer_irq_q;
	endproperty
	a_cap_only: assert property (p_cap_only)
		else $error("reload interrupt leaked through capture-only filter");

	property p_step;
		cmp_run && tick && count_q != TMR_CNT_MAX |=>
			count_q == $past(count_q) + 16'h0001;
	endproperty
	a_step: assert property (p_step)
		else $error("count did not advance by one per tick");

	// gated reload restarts the count, unlike the compare match
	property p_gate_reload;
		enable && mode == TMR_MODE_GATED && !count_load && match &&
			tin_act && interrupt_source_config != TMR_ICFG_CAP_ONLY |=>
			timer_irq_q && count_q == TMR_CNT_RESTART;
	endproperty
	a_gate_reload: assert property (p_gate_reload)
		else $error("gated reload did not restart or interrupt");

	property p_gate_step;
		enable && mode == TMR_MODE_GATED && !count_load && tick &&
			tin_act && !match |=> count_q == $past(count_q) + 16'h0001;
	endproperty
	a_gate_step: assert property (p_gate_step)
		else $error("gated count did not advance while input active");

	property p_cap_irq;
		cc_run && cap_ev && interrupt_source_config != TMR_ICFG_RLD_ONLY
			|=> timer_irq_q;
	endproperty
	a_cap_irq: assert property (p_cap_irq)
		else $error("capture raised no interrupt");

	// filter must hide captures, yet capture still restarts the count
	property p_rld_only;
		interrupt_source_config == TMR_ICFG_RLD_ONLY && cap_ev
			|=> !timer_irq_q;
	endproperty
	a_rld_only: assert property (p_rld_only)
		else $error("capture interrupt leaked through reload-only filter");

	c_cmp_match: cover property (cmp_run && match ##1 timer_irq_q);
	c_capture: cover property (cap_ev ##1 capture_cause_flag);
	c_cc_reload: cover property (cc_run && match && !cap_ev &&
		cc_q == TMR_CC_RUN);
	c_gate_irq: cover property (enable && mode == TMR_MODE_GATED &&
		deassert ##1 timer_irq_q);
	c_gate_reload: cover property (enable && mode == TMR_MODE_GATED &&
		match && tin_act ##1 timer_irq_q);

endmodule // tmr_top

/* bench/tmr_pin_model.sv */
// far-side model: whatever drives the timer input pin
// assumes mclk from the bench; wanted level comes from tb_top
`timescale 1ns/100ps
module tmr_pin_model (
	input wire logic mclk,
	input wire logic want,
	output logic timer_in
);
	// ******************************
	// pin level
	// ******************************
	int held;
	initial begin
		timer_in = 1'b0;
		held = 0;
	end
	// hold each level at least three full cycles so the synchroniser sees it
	always @(posedge mclk) begin
		held <= held + 1;
		if (want != timer_in && held >= 2) begin
			timer_in <= #1 want;
			held <= 0;
		end
	end
endmodule // tmr_pin_model

/* bench/tb_top.sv */
// self-checking bench for the compare / gated / capture timer
// assumes tmr_pkg compiled first; pin model drives timer_in
`timescale 1ns/100ps
module tb_top
	import tmr_pkg::*;
;
	logic mclk, reset, enable, input_polarity_bit, out_alt_en, out_init;
	logic count_load, want, timer_in, capture_cause_flag, timer_irq_q;
	logic timer_out_q, pol, oi;
	logic [1:0] mode, interrupt_source_config;
	logic [TMR_PS_W-1:0] prescale, ps;
	logic [15:0] count_load_value, reload_value, count_q;
	logic [15:0] capture_value_pair, prev, r;
	int n_errors, checks_done, cyc, irqs, seed, i, k;

	tmr_top DUT (.mclk(mclk), .reset(reset), .enable(enable),
		.mode(mode), .prescale(prescale),
		.input_polarity_bit(input_polarity_bit),
		.interrupt_source_config(interrupt_source_config),
		.out_alt_en(out_alt_en), .out_init(out_init),
		.count_load(count_load), .count_load_value(count_load_value),
		.reload_value(reload_value), .timer_in(timer_in),
		.count_q(count_q), .capture_value_pair(capture_value_pair),
		.capture_cause_flag(capture_cause_flag),
		.timer_irq_q(timer_irq_q), .timer_out_q(timer_out_q));
	tmr_pin_model PIN (.mclk(mclk), .want(want), .timer_in(timer_in));

	// ******************************
	// clock, timeout, observers
	// ******************************
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// prev holds the count from before each edge
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		prev <= count_q;
		if (timer_irq_q === 1'b1)
			irqs <= irqs + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up;
		end
	end

	// ******************************
	// expectations and helpers
	// ******************************
	function automatic logic irq_exp(input logic [1:0] c, input logic cap);
		return cap ? (c != 2'h3) : (c != 2'h2);
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// bounded wait for one interrupt pulse
	task automatic wait_irq(input int lim);
		int w;
		w = 0;
		step(1);
		while (timer_irq_q !== 1'b1 && w < lim) begin
			step(1);
			w++;
		end
		chk(timer_irq_q, 16'h1);
	endtask
	// disable, configure, load, then enable as the last step
	task automatic setup(input logic [1:0] m, input logic [2:0] p,
		input logic [1:0] cfg, input logic [15:0] ld, input logic [15:0] rl);
		enable = 1'b0;
		step(1);
		mode = m;
		prescale = p;
		input_polarity_bit = pol;
		interrupt_source_config = cfg;
		reload_value = rl;
		count_load = 1'b1;
		count_load_value = ld;
		step(1);
		count_load = 1'b0;
		enable = 1'b1;
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ******************************
	// main sequence
	// ******************************
	initial begin
		{enable, input_polarity_bit, out_alt_en, out_init, count_load} = 0;
		{mode, interrupt_source_config, prescale, want, pol} = 0;
		{count_load_value, reload_value, n_errors, checks_done} = 0;
		{cyc, irqs} = 0;
		seed = 32'he0ea1697;
		reset = 1'b1;
		step(3);
		reset = 1'b0;
		// compare runs; first one crosses the top of the count
		for (i = 0; i < 6; i++) begin
			r = (i == 0) ? 16'hffff : 16'($random(seed));
			k = (i == 0) ? 2 : 1 + ($random(seed) & 7);
			ps = (i == 0) ? 3'h0 : 3'($random(seed) & 3);
			oi = 1'($random(seed));
			out_init = oi;
			out_alt_en = i[0];
			setup(TMR_MODE_COMPARE, ps, 2'h0, r - 16'(k), r);
			want = ~want; // pin toggles must not matter
			wait_irq(120);
			chk(count_q, r + 16'h1);
			chk(timer_out_q, oi ^ out_alt_en);
		end
		// slowest prescale: one 128-cycle tick to reach the reload value, then the match tick
		setup(TMR_MODE_COMPARE, 3'h7, 2'h0, 16'h1233, 16'h1234);
		k = cyc;
		wait_irq(300);
		chk(16'(cyc - k), 16'd257);
		chk(count_q, 16'h1235);
		chk(timer_out_q, oi ^ out_alt_en);
		// gated: idle while inactive, count while active
		pol = 1'($random(seed));
		want = ~pol;
		setup(TMR_MODE_GATED, 3'h0, 2'h0, 16'h0100, 16'hf000);
		step(20);
		r = count_q;
		step(10);
		chk(count_q, r);
		want = pol;
		step(30);
		chk(16'(count_q > r + 16'd15), 16'h1);
		want = ~pol;
		wait_irq(10);
		r = count_q;
		step(10);
		chk(count_q, r);
		want = pol;
		setup(TMR_MODE_GATED, 3'h0, 2'h0, 16'h0001, 16'h0040);
		wait_irq(100);
		chk(count_q, TMR_CNT_RESTART);
		// idle code: the count stands whatever the pin does
		setup(2'h3, 3'h0, 2'h0, 16'h0055, 16'h0056);
		want = ~want;
		step(12);
		chk(count_q, 16'h0055);
		// capture/compare under every interrupt source setting
		for (i = 0; i < 4; i++) begin
			pol = 1'($random(seed));
			want = ~pol;
			step(6);
			setup(TMR_MODE_CAPCMP, 3'h0, 2'(i), 16'h0001, 16'h0200);
			irqs = 0;
			step(20);
			chk(count_q, 16'h1);
			want = pol;
			step(10);
			chk(16'(irqs), 16'h0);
			chk(16'(count_q > 16'h1), 16'h1);
			step(2 + ($random(seed) & 31));
			want = ~pol;
			step(6);
			want = pol;
			if (irq_exp(2'(i), 1'b1)) begin
				wait_irq(12);
				chk(capture_value_pair, prev);
				chk(count_q, 16'h1);
				chk(16'(capture_cause_flag), 16'h1);
			end
			if (irq_exp(2'(i), 1'b0)) begin
				wait_irq(16'h220);
				chk(count_q, 16'h1);
				chk(16'(capture_cause_flag), 16'h0);
			end else
				step(16'h220);
			step(2);
			r = 16'(irq_exp(2'(i), 1'b1)) + 16'(irq_exp(2'(i), 1'b0));
			chk(16'(irqs), r);
		end
		wrap_up;
	end
endmodule // tb_top
